// ---- rtl/boot_strap_capture.sv ----
// Reset-time strap capture with Wishbone register access and boot fetch start
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
module boot_strap_capture (
	input wire logic ref_clk,
	input wire logic reset,
	input wire boot_strap_pkg::strap_pins_t strap_pins,
	input wire logic emu_reset_req,
	input wire logic wdog_reset_req,
	input wire boot_strap_pkg::wb_req_t wb_req,
	output boot_strap_pkg::wb_rsp_t wb_rsp,
	output boot_strap_pkg::host_cfg_t host_cfg,
	output logic [boot_strap_pkg::ADDR_W-1:0] boot_fetch_addr,
	output logic boot_fetch_req
);
	import boot_strap_pkg::*;

	strap_pins_t pin_meta_r;
	strap_pins_t pin_sync_r;
	logic capture_pending_r;
	logic [BYTE_W-1:0] strap_low_r;
	logic [BYTE_W-1:0] strap_high_r;
	host_cfg_t host_cfg_r;
	logic [ADDR_W-1:0] boot_addr_r;
	logic boot_req_r;
	logic ack_r;
	logic [DATA_W-1:0] rd_dat_r;
	logic [DATA_W-1:0] rd_nxt;
	logic soft_reset;
	logic wb_hit;
	logic wb_commit;
	strap_pins_t cap;

	assign soft_reset = emu_reset_req | wdog_reset_req;
	assign wb_hit = wb_req.cyc & wb_req.stb & ~ack_r;
	assign wb_commit = wb_req.cyc & wb_req.stb & wb_req.we & ack_r; // Write lands at the ack edge
	assign cap = strap_pins_t'({strap_high_r, strap_low_r});

	// Pin synchroniser; no reset so the pins are already settled at release
	always_ff @(posedge ref_clk) begin
		pin_meta_r <= strap_pins;
		pin_sync_r <= pin_meta_r;
	end

	// Armed by external reset only, fires once on the first edge after release
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			capture_pending_r <= 1'b1;
		end else begin
			capture_pending_r <= 1'b0;
		end
	end

	// Strap capture; soft resets never reach here
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			strap_low_r <= STRAP_RESET;
			strap_high_r <= STRAP_RESET;
		end else if (capture_pending_r) begin
			strap_low_r <= pin_sync_r[LOW_LSB +: BYTE_W];
			strap_high_r <= pin_sync_r[HIGH_LSB +: BYTE_W];
		end
	end

	// Host port config: filled from straps in host boot, else software owned
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			host_cfg_r <= HCFG_RESET;
		end else if (capture_pending_r && !pin_sync_r.host_chip_select_pin) begin
			host_cfg_r.host_byte_addressing <= pin_sync_r.serial0_data_out_pin;
			host_cfg_r.host_full_width <= pin_sync_r.serial0_data_in_pin;
			host_cfg_r.host_nonmuxed_bus <= pin_sync_r.serial0_clock_pin;
		end else if (wb_commit && wb_req.sel[0] && wb_req.adr == HOST_CFG_ADDR) begin
			host_cfg_r <= wb_req.dat[HCFG_W-1:0];
		end
	end

	// Boot fetch always restarts at ROM base, after capture or a soft reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			boot_addr_r <= ROM_BOOT_ADDR;
			boot_req_r <= 1'b0;
		end else begin
			boot_addr_r <= ROM_BOOT_ADDR;
			boot_req_r <= capture_pending_r | soft_reset;
		end
	end

	// Read mux; reserved upper bits read as zero and reads change nothing
	always_comb begin
		rd_nxt = READ_ZERO;
		if (wb_req.adr == STRAP_LOW_ADDR) begin
			rd_nxt[BYTE_W-1:0] = strap_low_r;
		end else if (wb_req.adr == STRAP_HIGH_ADDR) begin
			rd_nxt[BYTE_W-1:0] = strap_high_r;
		end else if (wb_req.adr == HOST_CFG_ADDR) begin
			rd_nxt[HCFG_W-1:0] = host_cfg_r;
		end
	end

	// One-wait-state ack; unmapped addresses ack with zero data
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ack_r <= 1'b0;
			rd_dat_r <= READ_ZERO;
		end else begin
			ack_r <= wb_hit;
			rd_dat_r <= (wb_hit && !wb_req.we) ? rd_nxt : READ_ZERO;
		end
	end

	assign wb_rsp = '{ack: ack_r, dat: rd_dat_r};
	assign host_cfg = host_cfg_r;
	assign boot_fetch_addr = boot_addr_r;
	assign boot_fetch_req = boot_req_r;

	// Checks
	property p_boot_rom;
		@(posedge ref_clk) disable iff (reset)
		boot_fetch_req |-> boot_fetch_addr == ROM_BOOT_ADDR;
	endproperty
	a_boot_rom: assert property (p_boot_rom) else $error("boot fetch not at ROM base");

	// Sampled reset keeps the release edge, where flops still see reset, out of capture checks
	property p_boot_after_capture;
		@(posedge ref_clk) disable iff (reset)
		!reset && capture_pending_r |=> boot_fetch_req ##1 (boot_fetch_req == $past(soft_reset));
	endproperty
	a_boot_after_capture: assert property (p_boot_after_capture) else $error("no boot request");

	property p_capture_low;
		@(posedge ref_clk) disable iff (reset)
		!reset && capture_pending_r |=> strap_low_r == $past(pin_sync_r[LOW_LSB +: BYTE_W]);
	endproperty
	a_capture_low: assert property (p_capture_low) else $error("low strap not captured");

	property p_capture_high;
		@(posedge ref_clk) disable iff (reset)
		!reset && capture_pending_r |=> cap.host_chip_select_pin == $past(pin_sync_r.host_chip_select_pin)
			&& strap_high_r == $past(pin_sync_r[HIGH_LSB +: BYTE_W]);
	endproperty
	a_capture_high: assert property (p_capture_high) else $error("high strap not captured");

	property p_soft_reset_keeps;
		@(posedge ref_clk) disable iff (reset)
		(soft_reset && !capture_pending_r) |=> $stable(strap_low_r) && $stable(strap_high_r)
			&& boot_fetch_req;
	endproperty
	a_soft_reset_keeps: assert property (p_soft_reset_keeps) else $error("soft reset moved straps");

	property p_host_cfg;
		@(posedge ref_clk) disable iff (reset)
		(!reset && capture_pending_r && !pin_sync_r.host_chip_select_pin) |=>
			host_cfg == {cap.serial0_data_out_pin, cap.serial0_data_in_pin, cap.serial0_clock_pin};
	endproperty
	a_host_cfg: assert property (p_host_cfg) else $error("host config not copied");

	property p_read_low;
		@(posedge ref_clk) disable iff (reset)
		(wb_hit && !wb_req.we && wb_req.adr == STRAP_LOW_ADDR) |=>
			wb_rsp.ack && wb_rsp.dat == {24'h00_0000, strap_low_r};
	endproperty
	a_read_low: assert property (p_read_low) else $error("low strap read wrong");

	property p_read_high;
		@(posedge ref_clk) disable iff (reset)
		(wb_hit && !wb_req.we && wb_req.adr == STRAP_HIGH_ADDR) |=>
			wb_rsp.ack && wb_rsp.dat[DATA_W-1:BYTE_W] == 24'h00_0000
			&& wb_rsp.dat[BYTE_W-1:0] == strap_high_r;
	endproperty
	a_read_high: assert property (p_read_high) else $error("high strap read wrong");

	property p_straps_hold;
		@(posedge ref_clk) disable iff (reset)
		!capture_pending_r |=> $stable(strap_low_r) && $stable(strap_high_r);
	endproperty
	a_straps_hold: assert property (p_straps_hold) else $error("straps changed");

	property p_ack_single;
		@(posedge ref_clk) disable iff (reset)
		wb_rsp.ack |=> !wb_rsp.ack;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");

	property p_ack_after_take;
		@(posedge ref_clk) disable iff (reset)
		wb_hit |=> wb_rsp.ack;
	endproperty
	a_ack_after_take: assert property (p_ack_after_take) else $error("request not acked");

	// Fetch restarts only after a capture or a soft reset
	property p_boot_quiet;
		@(posedge ref_clk) disable iff (reset)
		(!capture_pending_r && !soft_reset) |=> !boot_fetch_req;
	endproperty
	a_boot_quiet: assert property (p_boot_quiet) else $error("boot fetch without reset");

	property p_soft_cfg;
		@(posedge ref_clk) disable iff (reset)
		(soft_reset && !capture_pending_r && !wb_commit) |=> $stable(host_cfg);
	endproperty
	a_soft_cfg: assert property (p_soft_cfg) else $error("soft reset moved config");

	c_host_boot: cover property (@(posedge ref_clk) disable iff (reset)
		capture_pending_r && !pin_sync_r.host_chip_select_pin);
	c_soft_reset: cover property (@(posedge ref_clk) disable iff (reset)
		soft_reset && !capture_pending_r);
	c_read_high: cover property (@(posedge ref_clk) disable iff (reset)
		wb_hit && !wb_req.we && wb_req.adr == STRAP_HIGH_ADDR);
	c_cfg_write: cover property (@(posedge ref_clk) disable iff (reset)
		wb_hit && wb_req.we && wb_req.adr == HOST_CFG_ADDR);

endmodule

// ---- rtl/boot_strap_pkg.sv ----
// Constants, register map and carrier types for the boot strap capture block
package boot_strap_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam int STRAP_W = 16;
	localparam int BYTE_W = 8;
	localparam int HCFG_W = 3;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] STRAP_LOW_ADDR = 32'h4000_0000;
	localparam logic [ADDR_W-1:0] STRAP_HIGH_ADDR = 32'h4000_0004;
	localparam logic [ADDR_W-1:0] HOST_CFG_ADDR = 32'h4000_0008;

	// Hardware boot always fetches from the bottom of internal ROM
	localparam logic [ADDR_W-1:0] ROM_BOOT_ADDR = 32'h0000_0000;

	// Field positions
	localparam int LOW_LSB = 0;
	localparam int HIGH_LSB = 8;
	localparam int HCFG_BYTE_ADDR_BIT = 2;
	localparam int HCFG_FULL_BIT = 1;
	localparam int HCFG_NONMUX_BIT = 0;

	// Reset values
	localparam logic [HCFG_W-1:0] HCFG_RESET = 3'h0;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
	localparam logic [BYTE_W-1:0] STRAP_RESET = 8'h00;

	// Captured pins, most significant first: high byte then low byte
	typedef struct packed {
		logic serial1_select_pin;
		logic serial1_enable_pin;
		logic host_chip_select_pin;
		logic host_data0_pin;
		logic host_addr0_pin;
		logic audio_tx_frame_sync0;
		logic audio_rx_frame_sync0;
		logic audio_serializer0_bit0;
		logic serial0_data_out_pin;
		logic serial0_data_in_pin;
		logic serial0_clock_pin;
		logic serial0_select_pin;
		logic serial0_enable_pin;
		logic serial1_data_out_pin;
		logic serial1_data_in_pin;
		logic serial1_clock_pin;
	} strap_pins_t;

	// Host port configuration bits filled from straps
	typedef struct packed {
		logic host_byte_addressing;
		logic host_full_width;
		logic host_nonmuxed_bus;
	} host_cfg_t;

	// Classic Wishbone request and response
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [SEL_W-1:0] sel;
		logic [ADDR_W-1:0] adr;
		logic [DATA_W-1:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [DATA_W-1:0] dat;
	} wb_rsp_t;

endpackage

// ---- testbench/boot_strap_capture_tb.sv ----
// Self-checking bench for strap capture, soft resets and register reads
`timescale 1ns/1ns
module boot_strap_capture_tb;
	import boot_strap_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic emu_reset_req = 1'b0;
	logic wdog_reset_req = 1'b0;
	logic [15:0] lvl = 16'h0000;
	logic [15:0] v;
	logic [31:0] rnd = 32'h2a7112c3;
	strap_pins_t strap_pins;
	wb_req_t wb_req = '0;
	wb_rsp_t wb_rsp;
	host_cfg_t host_cfg;
	logic [ADDR_W-1:0] boot_fetch_addr;
	logic boot_fetch_req;
	logic [DATA_W-1:0] exp_q[$];
	logic [3:0] modes [6] = '{4'h0, 4'ha, 4'h9, 4'hb, 4'hd, 4'hf};
	int miscompares = 0;
	int n_checks = 0;

	always #4 ref_clk = ~ref_clk;

	strap_board board_u (.level(lvl), .strap_pins(strap_pins));
	boot_strap_capture dut_u (
		.ref_clk(ref_clk), .reset(reset), .strap_pins(strap_pins),
		.emu_reset_req(emu_reset_req), .wdog_reset_req(wdog_reset_req),
		.wb_req(wb_req), .wb_rsp(wb_rsp), .host_cfg(host_cfg),
		.boot_fetch_addr(boot_fetch_addr), .boot_fetch_req(boot_fetch_req)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_sim();
		if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			miscompares++;
		end
	endtask

	// Single classic cycle; held until ack is sampled, then a idle cycle
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] e);
		if (!w) exp_q.push_back(e);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
		do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
		wb_req <= '0;
		@(posedge ref_clk);
	endtask

	// Read answers compared against the oldest expectation
	always @(posedge ref_clk) begin
		if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
			if (exp_q.size() == 0) chk("unexpected ack", 32'h1, 32'h0);
			else chk("read data", exp_q.pop_front(), wb_rsp.dat);
		end
	end

	// Hang guard, far beyond the six boot passes
	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		end_sim();
	end

	// One host boot and five non-host boot modes strapped, captured, then disturbed by soft resets
	initial begin
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			v = rnd[15:0];
			if (i > 0) {v[13], v[7:5]} = modes[i];
			else v[13] = 1'b0;
			lvl <= v;
			reset <= 1'b1;
			repeat (i == 0 ? 20 : 3) @(posedge ref_clk);
			reset <= 1'b0;
			repeat (2) @(posedge ref_clk);
			chk("boot_fetch_req", 32'h1, {31'h0, boot_fetch_req});
			chk("boot_fetch_addr", ROM_BOOT_ADDR, boot_fetch_addr);
			wb(1'b0, STRAP_LOW_ADDR, 32'h0, {24'h0, v[7:0]});
			wb(1'b0, STRAP_HIGH_ADDR, 32'h0, {24'h0, v[15:8]});
			chk("host_cfg", {29'h0, v[13] ? 3'h0 : v[7:5]}, {29'h0, host_cfg});
			// Pins move after boot; soft resets must not resample them
			lvl <= ~v;
			emu_reset_req <= 1'b1;
			@(posedge ref_clk);
			emu_reset_req <= 1'b0;
			wdog_reset_req <= 1'b1;
			@(posedge ref_clk);
			wdog_reset_req <= 1'b0;
			chk("boot_fetch_req soft", 32'h1, {31'h0, boot_fetch_req});
			repeat (3) @(posedge ref_clk);
			chk("boot_fetch_req idle", 32'h0, {31'h0, boot_fetch_req});
			wb(1'b1, STRAP_LOW_ADDR, {24'h0, ~v[7:0]}, 32'h0);
			wb(1'b0, STRAP_LOW_ADDR, 32'h0, {24'h0, v[7:0]});
			wb(1'b0, STRAP_HIGH_ADDR, 32'h0, {24'h0, v[15:8]});
			chk("host_cfg", {29'h0, v[13] ? 3'h0 : v[7:5]}, {29'h0, host_cfg});
		end
		wb(1'b0, 32'h4000_0010, 32'h0, 32'h0);
		for (int k = 5; k > 0; k -= 3) begin
			wb(1'b1, HOST_CFG_ADDR, 32'(k), 32'h0);
			wb(1'b0, HOST_CFG_ADDR, 32'h0, 32'(k));
			chk("host_cfg", 32'(k), {29'h0, host_cfg});
		end
		repeat (2) @(posedge ref_clk);
		end_sim();
	end
endmodule

// ---- testbench/strap_board.sv ----
// Board strap model driving the sampled device pins
`timescale 1ns/1ns
module strap_board (
	input wire logic [15:0] level,
	output boot_strap_pkg::strap_pins_t strap_pins
);
	import boot_strap_pkg::*;
	// Straps are static resistors; the bench picks chip select and boot pins
	assign strap_pins = strap_pins_t'(level);
endmodule
